// ===== logic/anps_defs.svh
/*
 * Offsets, field positions and reset values of the partner status registers.
 * Assumes inclusion by its bare name from the modules; the package does not include it.
 */
`ifndef ANPS_DEFS_SVH
`define ANPS_DEFS_SVH
`define IDX_PARTNER_ABILITY   8'h05
`define IDX_NEG_EXPANSION     8'h06
`define OFS_PARTNER_ABILITY   (`IDX_PARTNER_ABILITY * 8'h04)
`define OFS_NEG_EXPANSION     (`IDX_NEG_EXPANSION * 8'h04)
`define OFS_IRQ_STATUS        8'h40
`define OFS_IRQ_MASK          8'h44
`define OFS_NEG_CONTROL       8'h48
`define BIT_NP                15
`define BIT_ACK               14
`define BIT_RF                13
`define FLD_TECH_HI           12
`define FLD_TECH_LO           5
`define FLD_TECH_RSV_HI       12
`define FLD_TECH_RSV_LO       11
`define FLD_SEL_HI            4
`define FLD_SEL_LO            0
`define BIT_PD_FAULT          4
`define BIT_PARTNER_NP        3
`define BIT_LOCAL_NP          2
`define BIT_PAGE_RX           1
`define BIT_PARTNER_AN        0
`define RST_WORD16            16'h0000
`define RST_IRQ               4'h0
`define IRQ_W                 4
`define IRQ_PAGE              0
`define IRQ_PD_FAULT          1
`define IRQ_REMOTE_FAULT      2
`define IRQ_PARTNER_AN        3
`define CTL_AN_ENABLE         0
`define RST_CTL               1'h1
`endif

// ===== logic/anps_pkg.sv
/*
 * Types shared by the partner status register bank and its page capture.
 * Assumes anps_defs.svh is available on the include path.
 */
package anps_pkg;
    typedef enum logic [1:0] {
        NEG_IDLE = 2'b00,
        NEG_BASE = 2'b01,
        NEG_NEXT = 2'b11
    } neg_state_t;

    typedef struct packed {
        logic [15:0] word;
        logic        base;
        logic        seen;
    } page_t;
endpackage : anps_pkg

// ===== logic/anps_page_if.sv
/*
 * Carries a verified partner code word from capture logic to the register bank.
 * Assumes both ends share one clock.
 */
`timescale 1ns/10ps
interface anps_page_if;
    logic [15:0] word;
    logic        strobe;
    logic        base;
    modport source (output word, output strobe, output base);
    modport sink   (input  word, input  strobe, input  base);
endinterface : anps_page_if

// ===== logic/anps_page_capture.sv
/*
 * Tracks base page versus next pages within one negotiation.
 * Assumes code word and strobe are already synchronous to the clock.
 */
`timescale 1ns/10ps
`include "anps_defs.svh"
module anps_page_capture
    import anps_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        restart,
    input  wire logic [15:0] code_word,
    input  wire logic        word_valid,
    input  wire logic        word_ok,
    anps_page_if.source      pg
);
    typedef struct packed {
        neg_state_t  st;
        logic [15:0] word;
        logic        strobe;
        logic        base;
    } cap_t;

    cap_t q, next_q;

    always_comb begin
        next_q        = q;
        next_q.strobe = 1'b0;
        if (restart) begin
            next_q.st = NEG_IDLE;
        end else if (word_valid && word_ok) begin
            next_q.word   = code_word;
            next_q.strobe = 1'b1;
            case (q.st)
                NEG_IDLE: begin
                    next_q.base = 1'b1;
                    next_q.st   = NEG_BASE;
                end
                NEG_BASE, NEG_NEXT: begin
                    next_q.base = 1'b0;
                    next_q.st   = NEG_NEXT;
                end
                default: begin
                    next_q.st = NEG_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '{st: NEG_IDLE, word: `RST_WORD16, strobe: 1'b0, base: 1'b0};
        end else if (ce) begin
            q <= next_q;
        end
    end

    assign pg.word   = q.word;
    assign pg.strobe = q.strobe && ce;
    assign pg.base   = q.base;

    a_first_is_base: assert property (@(posedge clk) disable iff (rst)
        (ce && !restart && word_valid && word_ok && q.st == NEG_IDLE) |=> q.base)
        else $error("first code word not marked as base page");
    a_later_is_next: assert property (@(posedge clk) disable iff (rst)
        (ce && !restart && word_valid && word_ok && q.st != NEG_IDLE) |=> !q.base)
        else $error("later code word marked as base page");
endmodule : anps_page_capture

// ===== logic/anps_partner_regs.sv
/*
 * Partner ability and negotiation expansion registers behind an APB slave,
 * with sticky interrupt status, mask and one level interrupt.
 * Assumes receive-side inputs are from other logic on REF_CLK, except the
 * parallel-detect link flags which come from other domains and are synchronised.
 */
// The APB interface to the registers was left to the implementer.
//
// Operation
// - bit 15 shows partner next-page ability
// - bit 14 shows partner acknowledge
// - bit 13 remote fault, feeds status remote fault; BMSR_REMOTE_FAULT follows it only while AN_ENABLE is set
// - bits 12:5 partner technology abilities
// - bits 4:0 partner selector field
// - expansion bit 4 on both links valid
// - also fault when a link was lost
// - expansion bit 3 partner next-page able
// - expansion bit 2 always reads one
// - expansion bit 1 on verified page, self-clears
// - first word base page, later next pages
// - expansion bit 0 partner negotiation able
`timescale 1ns/10ps
`include "anps_defs.svh"
module anps_partner_regs
    import anps_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              REF_CLK,
    input  wire logic              RST,
    input  wire logic              CE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    input  wire logic [15:0]       CODE_WORD,
    input  wire logic              CODE_WORD_VALID,
    input  wire logic              CODE_WORD_OK,
    input  wire logic              NEG_RESTART,
    input  wire logic              LINK10_VALID,
    input  wire logic              LINK100_VALID,
    input  wire logic              PD_LINK_LOST,
    output logic                   BMSR_REMOTE_FAULT,
    output logic                   AN_ENABLE,
    output logic                   IRQ
);
    initial begin
        if (ADDR_W < 8 || ADDR_W > 32) begin
            $error("ADDR_W must hold the register offsets and fit 32 bits");
        end
    end

    typedef struct packed {
        logic [15:0]       ability;
        logic              pd_fault;
        logic              partner_np;
        logic              page_rx;
        logic              partner_an;
        logic [`IRQ_W-1:0] irq_status;
        logic [`IRQ_W-1:0] irq_mask;
        logic              an_enable;
        logic [1:0]        s10;
        logic [1:0]        s100;
        logic [1:0]        slost;
        logic [31:0]       rdata;
        logic              rvalid;
    } regs_t;

    regs_t q, next_q;
    anps_page_if pg ();

    anps_page_capture u_capture (
        .clk        (REF_CLK),
        .rst        (RST),
        .ce         (CE),
        .restart    (NEG_RESTART),
        .code_word  (CODE_WORD),
        .word_valid (CODE_WORD_VALID),
        .word_ok    (CODE_WORD_OK),
        .pg         (pg.source)
    );

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (32'(a) == {24'h000000, ofs});
    endfunction : hit

    logic        rd_load;
    logic        rd_done;
    logic        wr_acc;
    logic        rd_acc;
    logic        pd_event;
    logic [15:0] expansion;
    logic [`IRQ_W-1:0] ev;

    // read data is loaded once per transfer; a frozen setup edge loads in the access phase
    assign rd_load = PSEL && !PWRITE && !q.rvalid;
    assign wr_acc  = PSEL && PENABLE && PWRITE && CE;
    assign rd_acc  = PSEL && PENABLE && !PWRITE && CE;
    assign rd_done = rd_acc && q.rvalid;
    // second stage only: first synchroniser flop feeds nothing else
    assign pd_event = (q.s10[1] && q.s100[1]) || q.slost[1];

    always_comb begin
        expansion                   = `RST_WORD16;
        expansion[`BIT_PD_FAULT]    = q.pd_fault;
        expansion[`BIT_PARTNER_NP]  = q.partner_np;
        expansion[`BIT_LOCAL_NP]    = 1'b1;
        expansion[`BIT_PAGE_RX]     = q.page_rx;
        expansion[`BIT_PARTNER_AN]  = q.partner_an;
    end

    always_comb begin
        ev                    = '0;
        ev[`IRQ_PAGE]         = pg.strobe;
        ev[`IRQ_PD_FAULT]     = CE && pd_event;
        ev[`IRQ_REMOTE_FAULT] = pg.strobe && pg.base && pg.word[`BIT_RF];
        ev[`IRQ_PARTNER_AN]   = pg.strobe && pg.base;
    end

    always_comb begin
        next_q       = q;
        next_q.s10   = {q.s10[0], LINK10_VALID};
        next_q.s100  = {q.s100[0], LINK100_VALID};
        next_q.slost = {q.slost[0], PD_LINK_LOST};
        // clear only what the read reported; a set since the load survives
        if (hit(PADDR, `OFS_NEG_EXPANSION) && rd_done) begin
            next_q.pd_fault = q.pd_fault & ~q.rdata[`BIT_PD_FAULT];
            next_q.page_rx  = q.page_rx & ~q.rdata[`BIT_PAGE_RX];
        end
        if (pd_event) begin
            next_q.pd_fault = 1'b1;
        end
        if (pg.strobe) begin
            next_q.page_rx = 1'b1;
            if (pg.base) begin
                next_q.ability    = pg.word;
                next_q.ability[`FLD_TECH_RSV_HI:`FLD_TECH_RSV_LO] = 2'b00;
                next_q.partner_an = 1'b1;
                next_q.partner_np = pg.word[`BIT_NP];
            end
        end
        if (NEG_RESTART) begin
            next_q.partner_an = 1'b0;
        end
        if (wr_acc && hit(PADDR, `OFS_IRQ_STATUS)) begin
            next_q.irq_status = q.irq_status & ~PWDATA[`IRQ_W-1:0];
        end
        next_q.irq_status = next_q.irq_status | ev;
        if (wr_acc && hit(PADDR, `OFS_IRQ_MASK)) begin
            next_q.irq_mask = PWDATA[`IRQ_W-1:0];
        end
        if (wr_acc && hit(PADDR, `OFS_NEG_CONTROL)) begin
            next_q.an_enable = PWDATA[`CTL_AN_ENABLE];
        end
        if (rd_done) begin
            next_q.rvalid = 1'b0;
        end
        if (rd_load) begin
            next_q.rvalid = 1'b1;
            next_q.rdata = '0;
            if (hit(PADDR, `OFS_PARTNER_ABILITY)) begin
                next_q.rdata[15:0] = q.ability;
            end else if (hit(PADDR, `OFS_NEG_EXPANSION)) begin
                next_q.rdata[15:0] = expansion;
            end else if (hit(PADDR, `OFS_IRQ_STATUS)) begin
                next_q.rdata[`IRQ_W-1:0] = q.irq_status;
            end else if (hit(PADDR, `OFS_IRQ_MASK)) begin
                next_q.rdata[`IRQ_W-1:0] = q.irq_mask;
            end else if (hit(PADDR, `OFS_NEG_CONTROL)) begin
                next_q.rdata[`CTL_AN_ENABLE] = q.an_enable;
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            q <= '{ability: `RST_WORD16, pd_fault: 1'b0, partner_np: 1'b0,
                   page_rx: 1'b0, partner_an: 1'b0, irq_status: `RST_IRQ,
                   irq_mask: `RST_IRQ, an_enable: `RST_CTL, s10: 2'b00,
                   s100: 2'b00, slost: 2'b00, rdata: 32'h0000_0000, rvalid: 1'b0};
        end else if (CE) begin
            q <= next_q;
        end
    end

    logic mapped;
    assign mapped = hit(PADDR, `OFS_PARTNER_ABILITY) || hit(PADDR, `OFS_NEG_EXPANSION)
                 || hit(PADDR, `OFS_IRQ_STATUS) || hit(PADDR, `OFS_IRQ_MASK)
                 || hit(PADDR, `OFS_NEG_CONTROL);

    assign PRDATA            = q.rdata;
    assign PREADY            = CE && !(PSEL && PENABLE && !PWRITE && !q.rvalid);
    assign PSLVERR           = PSEL && PENABLE && (!mapped || (PWRITE
                               && (hit(PADDR, `OFS_PARTNER_ABILITY)
                               || hit(PADDR, `OFS_NEG_EXPANSION))));
    assign BMSR_REMOTE_FAULT = q.ability[`BIT_RF] && q.an_enable;
    assign AN_ENABLE         = q.an_enable;
    assign IRQ               = |(q.irq_status & q.irq_mask);

    sequence s_base_page;
        CE && pg.strobe && pg.base;
    endsequence
    sequence s_exp_read;
        rd_done && hit(PADDR, `OFS_NEG_EXPANSION);
    endsequence

    a_ability_load: assert property (@(posedge REF_CLK) disable iff (RST)
        s_base_page |=> q.ability[15:13] == $past(pg.word[15:13])
                        && q.ability[10:0] == $past(pg.word[10:0]))
        else $error("partner ability not loaded from base page");
    a_ability_hold: assert property (@(posedge REF_CLK) disable iff (RST)
        !(pg.strobe && pg.base) |=> $stable(q.ability))
        else $error("partner ability changed without a verified base page");
    a_reserved_tech: assert property (@(posedge REF_CLK) disable iff (RST)
        q.ability[`FLD_TECH_RSV_HI:`FLD_TECH_RSV_LO] == 2'b00)
        else $error("reserved ability bits set");
    a_remote_fault_out: assert property (@(posedge REF_CLK) disable iff (RST)
        (s_base_page ##0 pg.word[`BIT_RF] ##0 q.an_enable) ##1 q.an_enable
        |-> BMSR_REMOTE_FAULT)
        else $error("remote fault not reflected in status");
    a_np_able_one: assert property (@(posedge REF_CLK) disable iff (RST)
        (CE && rd_load && hit(PADDR, `OFS_NEG_EXPANSION)) |=> q.rdata[`BIT_LOCAL_NP])
        else $error("local next page bit not one");
    a_page_rx_set: assert property (@(posedge REF_CLK) disable iff (RST)
        (CE && pg.strobe) |=> q.page_rx)
        else $error("page received not set");
    a_page_rx_clear: assert property (@(posedge REF_CLK) disable iff (RST)
        (s_exp_read ##0 q.rdata[`BIT_PAGE_RX] ##0 !pg.strobe) |=> !q.page_rx)
        else $error("page received not cleared by read");
    a_pd_fault_set: assert property (@(posedge REF_CLK) disable iff (RST)
        (CE && q.s10[1] && q.s100[1]) |=> q.pd_fault)
        else $error("parallel detection fault not set");
    a_pd_lost_set: assert property (@(posedge REF_CLK) disable iff (RST)
        (CE && q.slost[1]) |=> q.pd_fault)
        else $error("lost link not flagged as fault");
    a_partner_an_np: assert property (@(posedge REF_CLK) disable iff (RST)
        (s_base_page ##0 !NEG_RESTART) |=> q.partner_an
        && q.partner_np == $past(pg.word[`BIT_NP]))
        else $error("partner negotiation or next page flag wrong");
endmodule : anps_partner_regs

// ===== verification/link_partner_model.sv
/*
 * Link partner model: hands verified or damaged code words to the receive side.
 * Assumes one clock shared with the register bank; the bench calls send.
 */
`timescale 1ns/10ps
module link_partner_model (
    input  wire logic        clk,
    output logic      [15:0] word,
    output logic             valid,
    output logic             ok
);
    initial begin
        word  = 16'h5a5a;
        valid = 1'b0;
        ok    = 1'b0;
    end

    // one-cycle word; afterwards the lines show the inverse so stale data never matches
    task automatic send(input logic [15:0] w, input logic good);
        word  <= w;
        valid <= 1'b1;
        ok    <= good;
        @(posedge clk);
        word  <= ~w;
        valid <= 1'b0;
        ok    <= ~good;
        @(posedge clk);
    endtask : send
endmodule : link_partner_model

// ===== verification/tb.sv
/*
 * Self-checking bench for the partner status register bank.
 * Assumes the design files and the link partner model are compiled first.
 */
`timescale 1ns/10ps
module tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        nr = 1'b0;
    logic        l10 = 1'b0;
    logic        l100 = 1'b0;
    logic        lost = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] cw;
    logic        cw_valid;
    logic        cw_ok;
    logic        bmsr_rf;
    logic        an_en;
    logic        irq;
    logic [31:0] rd;
    logic        er;
    logic [15:0] w;
    int          n_fail = 0;
    int          num_checks = 0;
    int          cycles = 0;

    anps_partner_regs dut (.REF_CLK(clk), .RST(rst), .CE(ce), .PADDR(paddr), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .CODE_WORD(cw), .CODE_WORD_VALID(cw_valid),
        .CODE_WORD_OK(cw_ok), .NEG_RESTART(nr), .LINK10_VALID(l10), .LINK100_VALID(l100),
        .PD_LINK_LOST(lost), .BMSR_REMOTE_FAULT(bmsr_rf), .AN_ENABLE(an_en), .IRQ(irq));

    link_partner_model partner (.clk(clk), .word(cw), .valid(cw_valid), .ok(cw_ok));

    always #2 clk = ~clk;

    task automatic finish_test;
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // one transfer, then one idle cycle so the next setup never lands in the same step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        check(rd, exp, what);
    endtask : rd_chk

    task automatic restart;
        nr <= 1'b1;
        @(posedge clk);
        nr <= 1'b0;
        @(posedge clk);
    endtask : restart

    function automatic logic [31:0] exp_x(input logic [15:0] b, input logic rx);
        return {28'h0, b[15], 1'b1, rx, 1'b1};
    endfunction : exp_x

    // reserved technology bits 12:11 always read zero
    function automatic logic [31:0] exp_ab(input logic [15:0] b);
        return {16'h0, b[15:13], 2'b00, b[10:0]};
    endfunction : exp_ab

    initial begin
        void'($urandom(32'h0fb0));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(8'h14, 32'h0, "ability reset");
        rd_chk(8'h18, 32'h4, "expansion reset");
        rd_chk(8'h48, 32'h1, "control reset");
        rd_chk(8'h40, 32'h0, "status reset");
        apb(1'b1, 8'h14, 32'hffff);
        check({31'h0, er}, 32'h1, "read-only write error");
        rd_chk(8'h14, 32'h0, "read-only kept");
        apb(1'b1, 8'h18, 32'h0);
        rd_chk(8'h18, 32'h4, "next-page able kept");
        rd_chk(8'h20, 32'h0, "unmapped data");
        check({31'h0, er}, 32'h1, "unmapped error");
        for (int i = 0; i < 8; i++) begin
            w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
            restart();
            partner.send(w, 1'b1);
            repeat (3) @(posedge clk);
            rd_chk(8'h14, exp_ab(w), "ability");
            check({31'h0, bmsr_rf}, {31'h0, w[13]}, "remote fault out");
            rd_chk(8'h18, exp_x(w, 1'b1), "expansion");
            rd_chk(8'h18, exp_x(w, 1'b0), "expansion cleared");
            partner.send(~w, 1'b0);
            repeat (3) @(posedge clk);
            rd_chk(8'h18, exp_x(w, 1'b0), "bad word no page");
            partner.send(~w, 1'b1);
            repeat (3) @(posedge clk);
            rd_chk(8'h14, exp_ab(w), "next page keeps ability");
            rd_chk(8'h18, exp_x(w, 1'b1), "next page received");
        end
        restart();
        partner.send(16'h2000, 1'b1);
        repeat (3) @(posedge clk);
        check({31'h0, bmsr_rf}, 32'h1, "remote fault set");
        apb(1'b1, 8'h48, 32'h0);
        check({30'h0, an_en, bmsr_rf}, 32'h0, "remote fault gated");
        apb(1'b1, 8'h48, 32'h1);
        ce <= 1'b0;
        partner.send(16'h1234, 1'b1);
        ce <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(8'h14, 32'h2000, "frozen word ignored");
        rd_chk(8'h18, 32'h7, "page before links");
        l10 <= 1'b1;
        repeat (6) @(posedge clk);
        l10 <= 1'b0;
        repeat (4) @(posedge clk);
        rd_chk(8'h18, 32'h5, "single link no fault");
        l10  <= 1'b1;
        l100 <= 1'b1;
        repeat (4) @(posedge clk);
        l10  <= 1'b0;
        l100 <= 1'b0;
        repeat (4) @(posedge clk);
        rd_chk(8'h18, 32'h15, "both links fault");
        rd_chk(8'h18, 32'h5, "fault self-clears");
        lost <= 1'b1;
        repeat (2) @(posedge clk);
        lost <= 1'b0;
        repeat (4) @(posedge clk);
        rd_chk(8'h18, 32'h15, "lost link fault");
        rd_chk(8'h18, 32'h5, "lost fault cleared");
        apb(1'b1, 8'h40, 32'hf);
        apb(1'b1, 8'h44, 32'h0);
        partner.send(16'h0001, 1'b1);
        repeat (3) @(posedge clk);
        apb(1'b0, 8'h40, 32'h0);
        check(rd & 32'h1, 32'h1, "page status");
        check({31'h0, irq}, 32'h0, "masked irq");
        apb(1'b1, 8'h44, 32'h1);
        check({31'h0, irq}, 32'h1, "unmasked irq");
        apb(1'b1, 8'h40, 32'h1);
        check({31'h0, irq}, 32'h0, "irq cleared");
        finish_test();
    end
endmodule : tb
